// File: sml_top.sv
// Serial modem-line mapping, break reset and cable-replacement sequencer.
// Assumes the link-side signals come from logic on clk_sys; the serial
// pins are asynchronous and are synchronised here.
//
// How it works
// RL1 - Receive line low longer than 100 ms drives a full hardware reset.
// RL2 - Break seen from host is never forwarded to the remote peer.
// RL3 - Host keeps receive line high while idle; low means reset.
// RL4 - Four modem bits are exchanged with the peer over the link.
// RL5 - Three mapping settings route any remote bit to any local line.
// RL6 - Cable mode connects after power-up and retries forever when lost.
// RL7 - Master waits programmable 100..15000 ms, default 2 s, after a failed try.
// RL8 - In ready-drop mode losing data-set-ready returns to command state.
// RL9 - Host must hold data-set-ready asserted (low) for auto connection.
// RL10 - Slave with stored master address accepts only that address.
// RL11 - Master stays hidden; slave discoverability follows the discoverable bit.
// RL12 - Request-to-send drops when full; device stops when clear-to-send drops.
// RL13 - Host should handshake properly, not loop clear to request.
// RL14 - Active-low reset pin plus power-on reset both reset the device.
// RL15 - Ready lost while linked gives command state, drop after timeout.
// RL16 - Ring output rests idle, asserts on incoming call until answered or rejected.
// RL17 - Carrier output asserted only while a connection is active.
// RL18 - Break counter counts low cycles, clears on high, fires at threshold.
`timescale 1ns/1ps
`default_nettype none

module sml_top
  import sml_pkg::*;
#(
  parameter int unsigned BREAK_CYCLES = BREAK_CYC,
  parameter int unsigned MS_CYCLES    = MS_CYC
) (
  input  wire  logic              clk_sys,
  input  wire  logic              rst,
  input  wire  logic              ce,
  input  wire  logic [ADDR_W-1:0] reg_addr,
  input  wire  logic [31:0]       reg_wdata,
  input  wire  logic              reg_wr,
  input  wire  logic              reg_rd,
  output var   logic [31:0]       reg_rdata,
  output var   logic              irq,
  input  wire  logic              rx_pin,
  input  wire  logic              dsr_n_pin,
  input  wire  logic              cts_n_pin,
  input  wire  logic              reset_n_pin,
  output var   logic              rts_n,
  output var   logic              dtr_n,
  output var   logic              dcd_n,
  output var   logic              ri_n,
  output var   logic              tx_allowed,
  output var   logic              hw_reset,
  input  wire  logic              rx_full,
  input  wire  logic              link_up,
  input  wire  logic              conn_fail,
  input  wire  logic              incoming_req,
  input  wire  logic [47:0]       incoming_addr,
  input  wire  logic [3:0]        remote_bits,
  output var   logic [3:0]        local_bits,
  output var   logic              break_fwd,
  output var   logic              connect_req,
  output var   logic              accept_req,
  output var   logic              reject_req,
  output var   logic              drop_req,
  output var   logic              discoverable,
  output var   logic              cmd_state
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] clamp_ms(input logic [15:0] v);
    if (v < RETRY_MIN_MS) begin
      return RETRY_MIN_MS;
    end
    if (v > RETRY_MAX_MS) begin
      return RETRY_MAX_MS;
    end
    return v;
  endfunction

  function automatic logic pick_local(input logic [1:0] src,
                                      input logic dsr, input logic cts);
    unique case (src)
      SRC_DSR:  return dsr;
      SRC_CTS:  return cts;
      SRC_ONE:  return 1'b1;
      SRC_ZERO: return 1'b0;
    endcase
  endfunction

  // ************************************************************
  // Pin synchronisers and break detector
  // ************************************************************
  logic [3:0]  sync1, sync2;
  logic [23:0] brk_cnt, next_brk_cnt;
  logic        next_hw_reset, next_rts_n, next_tx_allowed, next_break_fwd;
  logic        rx_s, dsr_s, cts_s, rst_pin_s, brk_hit;

  assign rx_s      = sync2[0];
  assign dsr_s     = ~sync2[1];
  assign cts_s     = ~sync2[2];
  assign rst_pin_s = ~sync2[3];

  always_comb begin
    next_brk_cnt = brk_cnt;
    brk_hit      = 1'b0;
    if (rx_s) begin
      next_brk_cnt = '0; // RL18
    end else if (brk_cnt < 24'(BREAK_CYCLES)) begin
      next_brk_cnt = brk_cnt + 24'h000001; // RL18 RL3
    end
    if (next_brk_cnt == 24'(BREAK_CYCLES)) begin
      brk_hit = 1'b1; // RL1
    end
    // Held from the threshold until the line goes high, so the reset covers the event
    next_hw_reset   = brk_hit | rst_pin_s; // RL1 RL14
    next_rts_n      = rx_full; // RL12
    next_tx_allowed = cts_s; // RL12
    next_break_fwd  = 1'b0; // RL2
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1      <= 4'hF;
      sync2      <= 4'hF;
      brk_cnt    <= '0;
      hw_reset   <= 1'b1; // RL14
      rts_n      <= 1'b1;
      tx_allowed <= 1'b0;
      break_fwd  <= 1'b0;
    end else if (ce) begin
      sync1      <= {reset_n_pin, cts_n_pin, dsr_n_pin, rx_pin};
      sync2      <= sync1;
      brk_cnt    <= next_brk_cnt;
      hw_reset   <= next_hw_reset;
      rts_n      <= next_rts_n;
      tx_allowed <= next_tx_allowed;
      break_fwd  <= next_break_fwd;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [CTRL_W-1:0] ctrl, next_ctrl;
  logic [7:0]        map_out, next_map_out, map_in, next_map_in;
  logic [1:0]        map_dir, next_map_dir;
  logic [15:0]       retry_ms, next_retry_ms, drop_ms, next_drop_ms;
  logic [ST_W-1:0]   status, next_status, mask, next_mask, events;
  logic [47:0]       permit, next_permit;
  logic [31:0]       next_rdata;
  logic              next_irq, answer_wr, reject_wr;
  sml_state_type     state;

  assign answer_wr = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_ANSWER];
  assign reject_wr = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_REJECT];

  always_comb begin
    next_ctrl     = ctrl;
    next_map_out  = map_out;
    next_map_in   = map_in;
    next_map_dir  = map_dir;
    next_retry_ms = retry_ms;
    next_drop_ms  = drop_ms;
    next_mask     = mask;
    next_permit   = permit;
    next_rdata    = '0;
    next_status   = status;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL:      next_ctrl = reg_wdata[CTRL_W-1:0];
        REG_MAP_OUT:   next_map_out = reg_wdata[7:0]; // RL5
        REG_MAP_DIR:   next_map_dir = reg_wdata[1:0]; // RL5
        REG_MAP_IN:    next_map_in = reg_wdata[7:0]; // RL5
        REG_RETRY:     next_retry_ms = clamp_ms(reg_wdata[15:0]); // RL7
        REG_DSR_DROP:  next_drop_ms = reg_wdata[15:0];
        REG_MASK:      next_mask = reg_wdata[ST_W-1:0];
        REG_PERMIT_LO: next_permit[31:0] = reg_wdata;
        REG_PERMIT_HI: next_permit[47:32] = reg_wdata[15:0];
        default:       next_rdata = '0;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:      next_rdata = 32'(ctrl);
        REG_MAP_OUT:   next_rdata = 32'(map_out);
        REG_MAP_DIR:   next_rdata = 32'(map_dir);
        REG_MAP_IN:    next_rdata = 32'(map_in);
        REG_RETRY:     next_rdata = 32'(retry_ms);
        REG_DSR_DROP:  next_rdata = 32'(drop_ms);
        REG_STATUS:    next_rdata = 32'(status);
        REG_MASK:      next_rdata = 32'(mask);
        REG_STATE:     next_rdata = {16'h0000, remote_bits, cmd_state,
                                     dsr_s, 4'h0, state};
        REG_PERMIT_LO: next_rdata = permit[31:0];
        REG_PERMIT_HI: next_rdata = 32'(permit[47:32]);
        default:       next_rdata = '0;
      endcase
      if (reg_addr == REG_STATUS) begin
        next_status = '0;
      end
    end
    // An event in the clearing cycle survives the clear
    next_status = next_status | events;
    next_irq    = |(next_status & mask);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl      <= '0;
      map_out   <= MAP_OUT_RST;
      map_dir   <= '0;
      map_in    <= MAP_IN_RST;
      retry_ms  <= RETRY_DEF_MS; // RL7
      drop_ms   <= DSR_DROP_DEF_MS;
      status    <= '0;
      mask      <= '0;
      permit    <= '0;
      reg_rdata <= '0;
      irq       <= 1'b0;
    end else if (ce) begin
      ctrl      <= next_ctrl;
      map_out   <= next_map_out;
      map_dir   <= next_map_dir;
      map_in    <= next_map_in;
      retry_ms  <= next_retry_ms;
      drop_ms   <= next_drop_ms;
      status    <= next_status;
      mask      <= next_mask;
      permit    <= next_permit;
      reg_rdata <= next_rdata;
      irq       <= next_irq;
    end
  end

  // ************************************************************
  // Connection sequencer and modem lines
  // ************************************************************
  sml_state_type next_state;
  logic [15:0]   ms_cnt, next_ms_cnt, wait_ms, next_wait_ms;
  logic [15:0]   dsr_ms, next_dsr_ms;
  logic          next_connect, next_accept, next_reject, next_drop;
  logic          next_cmd, next_discov, ms_tick, linked, ringing;
  logic          next_dtr_n, next_dcd_n, next_ri_n;
  logic [3:0]    next_local;

  assign ms_tick = ms_cnt == 16'(MS_CYCLES - 1);
  assign linked  = state == SML_LINKED;
  assign ringing = state == SML_RINGING;

  always_comb begin
    next_state   = state;
    next_ms_cnt  = ms_tick ? '0 : ms_cnt + 16'h0001;
    next_wait_ms = wait_ms;
    next_dsr_ms  = '0;
    next_connect = 1'b0;
    next_accept  = 1'b0;
    next_reject  = 1'b0;
    next_drop    = 1'b0;
    events       = '0;
    events[ST_BREAK] = brk_hit;
    unique case (state)
      SML_IDLE: begin
        if (!ctrl[CTRL_MASTER]) begin
          next_state = SML_LISTEN;
        end else if (ctrl[CTRL_CABLE] && dsr_s) begin
          next_state   = SML_DIAL; // RL6 RL9
          next_connect = 1'b1;
        end
      end
      SML_DIAL: begin
        if (link_up) begin
          next_state = SML_LINKED;
          events[ST_LINK_UP] = 1'b1;
        end else if (conn_fail) begin
          next_state   = SML_BACKOFF; // RL7
          next_wait_ms = '0;
          // Fresh prescaler phase so the retry never comes early
          next_ms_cnt  = '0;
        end
      end
      SML_BACKOFF: begin
        if (ms_tick) begin
          next_wait_ms = wait_ms + 16'h0001;
        end
        if (wait_ms >= retry_ms) begin
          next_state   = SML_DIAL; // RL7 RL6
          next_connect = 1'b1;
        end
      end
      SML_LISTEN: begin
        // Role switched to master after reset: go back to idle, which dials in cable mode with ready held
        if (ctrl[CTRL_MASTER]) begin
          next_state = SML_IDLE; // RL6
        end else if (link_up) begin
          next_state = SML_LINKED;
          events[ST_LINK_UP] = 1'b1;
        end else if (incoming_req) begin
          if (ctrl[CTRL_PERMIT] && incoming_addr != permit) begin
            next_reject = 1'b1; // RL10
          end else if (ctrl[CTRL_CABLE]) begin
            next_accept = 1'b1; // RL6
          end else begin
            next_state = SML_RINGING; // RL16
            events[ST_RING] = 1'b1;
          end
        end
      end
      SML_RINGING: begin
        if (answer_wr) begin
          next_state  = SML_LISTEN; // RL16
          next_accept = 1'b1;
        end else if (reject_wr) begin
          next_state  = SML_LISTEN; // RL16
          next_reject = 1'b1;
        end
      end
      SML_LINKED: begin
        if (!dsr_s && ctrl[CTRL_DSR_DROP]) begin
          next_dsr_ms = dsr_ms + 16'(ms_tick);
        end
        if (!link_up) begin
          events[ST_LINK_LOST] = 1'b1;
          next_state = SML_IDLE; // RL6
        end else if (!dsr_s && ctrl[CTRL_DSR_DROP] && dsr_ms >= drop_ms) begin
          next_drop  = 1'b1; // RL15
          next_state = SML_IDLE;
          events[ST_DSR_DROP] = 1'b1;
        end
      end
      default: next_state = SML_IDLE;
    endcase
    // Ready-drop mode: host pulls the line to get the command parser
    next_cmd    = !linked || (ctrl[CTRL_DSR_DROP] && !dsr_s); // RL8 RL15
    next_discov = !ctrl[CTRL_MASTER] && ctrl[CTRL_DISCOV]; // RL11
    // Remote bit selected per line, else connection state drives it
    next_dtr_n = ~(linked & remote_bits[map_out[1:0]]); // RL5 RL4
    next_dcd_n = map_dir[0] ? ~(linked & remote_bits[map_out[3:2]])
                            : ~linked; // RL17 RL5
    next_ri_n  = map_dir[1] ? ~(linked & remote_bits[map_out[5:4]])
                            : ~ringing; // RL16 RL5
    for (int i = 0; i < 4; i++) begin
      next_local[i] = linked & pick_local(map_in[2*i +: 2], dsr_s,
                                          cts_s); // RL4
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state        <= SML_IDLE;
      ms_cnt       <= '0;
      wait_ms      <= '0;
      dsr_ms       <= '0;
      connect_req  <= 1'b0;
      accept_req   <= 1'b0;
      reject_req   <= 1'b0;
      drop_req     <= 1'b0;
      cmd_state    <= 1'b1;
      discoverable <= 1'b0;
      dtr_n        <= 1'b1;
      dcd_n        <= 1'b1;
      ri_n         <= 1'b1;
      local_bits   <= '0;
    end else if (ce) begin
      state        <= next_state;
      ms_cnt       <= next_ms_cnt;
      wait_ms      <= next_wait_ms;
      dsr_ms       <= next_dsr_ms;
      connect_req  <= next_connect;
      accept_req   <= next_accept;
      reject_req   <= next_reject;
      drop_req     <= next_drop;
      cmd_state    <= next_cmd;
      discoverable <= next_discov;
      dtr_n        <= next_dtr_n;
      dcd_n        <= next_dcd_n;
      ri_n         <= next_ri_n;
      local_bits   <= next_local;
    end
  end

endmodule

`default_nettype wire

// File: sml_pkg.sv
// Constants shared by the serial modem-line and break-reset block.
// Assumes a single 20 MHz system clock and a plain register port.
package sml_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_CYC        = CLK_HZ / 1000;
  localparam int unsigned BREAK_MS      = 100;
  // Break must last longer than its time, so one cycle beyond it
  localparam int unsigned BREAK_CYC     = BREAK_MS * MS_CYC + 1;
  localparam logic [15:0] RETRY_DEF_MS  = 16'h07D0;
  localparam logic [15:0] RETRY_MIN_MS  = 16'h0064;
  localparam logic [15:0] RETRY_MAX_MS  = 16'h3A98;
  localparam logic [15:0] DSR_DROP_DEF_MS = 16'h03E8;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_MAP_OUT   = 8'h04;
  localparam logic [7:0] REG_MAP_DIR   = 8'h08;
  localparam logic [7:0] REG_MAP_IN    = 8'h0C;
  localparam logic [7:0] REG_RETRY     = 8'h10;
  localparam logic [7:0] REG_DSR_DROP  = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;
  localparam logic [7:0] REG_MASK      = 8'h1C;
  localparam logic [7:0] REG_STATE     = 8'h20;
  localparam logic [7:0] REG_PERMIT_LO = 8'h24;
  localparam logic [7:0] REG_PERMIT_HI = 8'h28;

  // Control bits
  localparam int unsigned CTRL_CABLE    = 0;
  localparam int unsigned CTRL_MASTER   = 1;
  localparam int unsigned CTRL_DISCOV   = 2;
  localparam int unsigned CTRL_DSR_DROP = 3;
  localparam int unsigned CTRL_PERMIT   = 4;
  localparam int unsigned CTRL_ANSWER   = 6;
  localparam int unsigned CTRL_REJECT   = 7;
  localparam int unsigned CTRL_W        = 5;

  // Status / mask bits
  localparam int unsigned ST_LINK_UP  = 0;
  localparam int unsigned ST_LINK_LOST = 1;
  localparam int unsigned ST_RING     = 2;
  localparam int unsigned ST_BREAK    = 3;
  localparam int unsigned ST_DSR_DROP = 4;
  localparam int unsigned ST_W        = 5;

  // Local source codes for outgoing modem bits
  localparam logic [1:0] SRC_DSR  = 2'h0;
  localparam logic [1:0] SRC_CTS  = 2'h1;
  localparam logic [1:0] SRC_ONE  = 2'h2;
  localparam logic [1:0] SRC_ZERO = 2'h3;

  localparam logic [7:0] MAP_OUT_RST = 8'h0B;
  localparam logic [7:0] MAP_IN_RST  = 8'hE0;

  typedef enum logic [5:0] {
    SML_IDLE    = 6'b000001,
    SML_DIAL    = 6'b000010,
    SML_BACKOFF = 6'b000100,
    SML_LISTEN  = 6'b001000,
    SML_RINGING = 6'b010000,
    SML_LINKED  = 6'b100000
  } sml_state_type;

endpackage

// File: sml_props.sv
// Port-level checker for the modem-line and break-reset block.
// Assumes one clock domain and sees only ports of sml_top.
`timescale 1ns/1ps
`default_nettype none

module sml_props
  import sml_pkg::*;
#(
  parameter int unsigned BREAK_CYCLES = BREAK_CYC,
  parameter int unsigned MS_CYCLES    = MS_CYC
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        rx_pin,
  input wire logic        reset_n_pin,
  input wire logic        rx_full,
  input wire logic        rts_n,
  input wire logic        hw_reset,
  input wire logic        break_fwd,
  input wire logic        link_up,
  input wire logic        dcd_n,
  input wire logic        incoming_req,
  input wire logic        ri_n,
  input wire logic        accept_req,
  input wire logic        connect_req
);
  // ********
  // Low-run counter, saturating so long breaks never wrap
  // ********
  int unsigned low_run;
  int unsigned next_low_run;
  always_comb begin
    next_low_run = low_run;
    if (rx_pin)
      next_low_run = 0;
    else if (low_run < 4000)
      next_low_run = low_run + 1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      low_run <= 0;
    else
      low_run <= next_low_run;
  end

  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence pin_held_low;
    !reset_n_pin [*5];
  endsequence
  sequence ring_clear;
    ##[0:2] ri_n;
  endsequence

  no_fwd_a: assert property (!break_fwd)
    else $error("break indication forwarded");
  rts_follow_a: assert property (
    !$past(rst) |-> rts_n == $past(rx_full))
    else $error("rts_n not following buffer full");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  break_reset_a: assert property (
    low_run >= BREAK_CYCLES + 5 |-> hw_reset)
    else $error("long break gave no reset");
  break_clear_a: assert property (
    (rx_pin && reset_n_pin) [*6] |-> !hw_reset)
    else $error("reset held with line high");
  pin_reset_a: assert property (pin_held_low |-> hw_reset)
    else $error("reset pin ignored");
  dcd_idle_a: assert property (!link_up [*3] |-> dcd_n)
    else $error("carrier asserted without link");
  ri_cause_a: assert property (
    $fell(ri_n) |-> $past(incoming_req) || $past(incoming_req, 2))
    else $error("ring without incoming request");
  accept_ring_a: assert property (accept_req |-> ring_clear)
    else $error("ring stays after answer");
  connect_pulse_a: assert property (connect_req |=> !connect_req)
    else $error("connect request longer than a pulse");
endmodule

bind sml_top sml_props #(
  .BREAK_CYCLES(BREAK_CYCLES),
  .MS_CYCLES   (MS_CYCLES)
) chk (
  .clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_pin(rx_pin), .reset_n_pin(reset_n_pin), .rx_full(rx_full),
  .rts_n(rts_n), .hw_reset(hw_reset), .break_fwd(break_fwd),
  .link_up(link_up), .dcd_n(dcd_n), .incoming_req(incoming_req),
  .ri_n(ri_n), .accept_req(accept_req), .connect_req(connect_req)
);
`default_nettype wire

// File: sml_host_model.sv
// Host terminal on the serial lines: break, ready and handshake.
// Assumes the bench drives its controls on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module sml_host_model (
  input  wire logic brk,
  input  wire logic dsr_on,
  input  wire logic ready,
  input  wire logic rts_n,
  output wire logic rx_pin,
  output wire logic dsr_n_pin,
  output wire logic cts_n_pin,
  output wire logic may_send
);
  assign rx_pin    = !brk;
  assign dsr_n_pin = !dsr_on;
  // Own readiness, never looped back from rts_n
  assign cts_n_pin = !ready;
  assign may_send  = !rts_n;
endmodule
`default_nettype wire

// File: sml_tb_top.sv
// Self-checking bench for sml_top with a host model on the pins.
// Assumes shortened break and millisecond counts via parameters.
`timescale 1ns/1ps
`default_nettype none

module sml_tb_top;
  import sml_pkg::*;
  localparam int BC = 20;
  localparam int MC = 4;
  localparam int CONN = 0, REJ = 1, DROP = 2;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic rx_full = 1'b0, link_up = 1'b0, conn_fail = 1'b0;
  logic incoming_req = 1'b0, reset_n_pin = 1'b1;
  logic brk = 1'b0, dsr_on = 1'b1, ready = 1'b1, may_send;
  logic [47:0] incoming_addr = 48'h0;
  logic [3:0]  remote_bits = 4'h0, local_bits;
  logic rx_pin, dsr_n_pin, cts_n_pin, irq, rts_n, dtr_n, dcd_n, ri_n;
  logic tx_allowed, hw_reset, break_fwd, connect_req, accept_req;
  logic reject_req, drop_req, discoverable, cmd_state;
  int err_count = 0, checks_done = 0, n;

  always #25 clk_sys = ~clk_sys;

  sml_top #(.BREAK_CYCLES(BC), .MS_CYCLES(MC)) uut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .rx_pin(rx_pin),
    .dsr_n_pin(dsr_n_pin), .cts_n_pin(cts_n_pin),
    .reset_n_pin(reset_n_pin), .rts_n(rts_n), .dtr_n(dtr_n),
    .dcd_n(dcd_n), .ri_n(ri_n), .tx_allowed(tx_allowed),
    .hw_reset(hw_reset), .rx_full(rx_full), .link_up(link_up),
    .conn_fail(conn_fail), .incoming_req(incoming_req),
    .incoming_addr(incoming_addr), .remote_bits(remote_bits),
    .local_bits(local_bits), .break_fwd(break_fwd),
    .connect_req(connect_req), .accept_req(accept_req),
    .reject_req(reject_req), .drop_req(drop_req),
    .discoverable(discoverable), .cmd_state(cmd_state));

  sml_host_model host (.brk(brk), .dsr_on(dsr_on), .ready(ready),
    .rts_n(rts_n), .rx_pin(rx_pin), .dsr_n_pin(dsr_n_pin),
    .cts_n_pin(cts_n_pin), .may_send(may_send));

  // ********
  // Tasks: outputs are read right after an edge, before it lands
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    cyc(1); reg_wr <= 1'b0; cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a; reg_rd <= 1'b1;
    cyc(1); reg_rd <= 1'b0; cyc(1);
    chk(reg_rdata, exp);
  endtask
  function automatic logic pulse_of(input int sel);
    return (sel == CONN) ? connect_req : (sel == REJ) ? reject_req : drop_req;
  endfunction
  task automatic wait_hi(input int sel, input int lim);
    n = 0;
    do begin cyc(1); n++; end while (pulse_of(sel) !== 1'b1 && n < lim);
    chk({31'h0, pulse_of(sel)}, 32'h1);
  endtask
  task automatic ring(input logic [47:0] a);
    incoming_addr <= a; incoming_req <= 1'b1; cyc(1); incoming_req <= 1'b0;
  endtask
  task automatic do_reset;
    rst <= 1'b1; cyc(5); rst <= 1'b0; cyc(1);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #(20000 * 50);
    err_count++;
    finish_test();
  end

  initial begin
    do_reset();
    cyc(1); chk(hw_reset, 1'b0);
    rd(REG_MAP_OUT, 32'h0000000B);
    rd(REG_MAP_IN, 32'h000000E0);
    rd(REG_RETRY, 32'h000007D0);
    rd(8'hFC, 32'h0);
    wr(REG_RETRY, 32'h5); rd(REG_RETRY, 32'h64);
    wr(REG_RETRY, 32'hFFFF); rd(REG_RETRY, 32'h3A98);
    wr(REG_RETRY, 32'h64); wr(REG_MASK, 32'h1F);
    // Master in cable mode with the slave-discoverable bit set too
    wr(REG_CTRL, 32'h07); wait_hi(CONN, 10);
    chk(discoverable, 1'b0);
    conn_fail <= 1'b1; cyc(1); conn_fail <= 1'b0;
    wait_hi(CONN, 600); chk(n >= 400 && n <= 408, 1);
    link_up <= 1'b1; cyc(3); chk(dcd_n, 1'b0);
    chk(cmd_state, 1'b0); chk(irq, 1'b1);
    rd(REG_STATUS, 32'h1); cyc(1); chk(irq, 1'b0);
    wr(REG_MAP_IN, 32'h4E); cyc(2); chk(local_bits, 4'hD);
    for (int i = 0; i < 4; i++) begin
      wr(REG_MAP_OUT, 32'h8 | i);
      remote_bits <= 4'h1 << i; cyc(3); chk(dtr_n, 1'b0);
      remote_bits <= ~(4'h1 << i); cyc(3); chk(dtr_n, 1'b1);
    end
    wr(REG_MAP_DIR, 32'h1); remote_bits <= 4'h8; cyc(3);
    chk(dcd_n, 1'b1);
    wr(REG_MAP_DIR, 32'h0); cyc(2); chk(dcd_n, 1'b0);
    rx_full <= 1'b1; cyc(2); chk(rts_n, 1'b1); chk(may_send, 1'b0);
    rx_full <= 1'b0; cyc(2); chk(rts_n, 1'b0);
    ready <= 1'b0; cyc(4); chk(tx_allowed, 1'b0);
    ready <= 1'b1; cyc(4); chk(tx_allowed, 1'b1);
    wr(REG_MASK, 32'h0); link_up <= 1'b0; wait_hi(CONN, 8);
    chk(irq, 1'b0); wr(REG_MASK, 32'h1F); cyc(1); chk(irq, 1'b1);
    rd(REG_STATUS, 32'h2); link_up <= 1'b1; cyc(3);
    wr(REG_DSR_DROP, 32'h2); wr(REG_CTRL, 32'h0B);
    dsr_on <= 1'b0; cyc(5); chk(cmd_state, 1'b1);
    wait_hi(DROP, 30);
    dsr_on <= 1'b1; link_up <= 1'b0;
    do_reset();
    brk <= 1'b1; cyc(BC - 3); brk <= 1'b0;
    repeat (8) begin cyc(1); chk(hw_reset, 1'b0); end
    brk <= 1'b1; cyc(BC + 6); chk(hw_reset, 1'b1);
    brk <= 1'b0; cyc(6); chk(hw_reset, 1'b0);
    rd(REG_STATUS, 32'h8);
    reset_n_pin <= 1'b0; cyc(5); chk(hw_reset, 1'b1);
    reset_n_pin <= 1'b1; cyc(6); chk(hw_reset, 1'b0);
    wr(REG_PERMIT_LO, 32'h00112233); wr(REG_PERMIT_HI, 32'h4455);
    wr(REG_CTRL, 32'h14); cyc(1); chk(discoverable, 1'b1);
    ring(48'h445500112234); wait_hi(REJ, 4);
    ring(48'h445500112233); cyc(2); chk(ri_n, 1'b0);
    wr(REG_CTRL, 32'h54); chk(accept_req, 1'b1);
    cyc(1); chk(ri_n, 1'b1);
    link_up <= 1'b1; cyc(3); link_up <= 1'b0; cyc(3);
    wr(REG_CTRL, 32'h04); ring(48'h0A0B0C0D0E0F); cyc(2);
    chk(ri_n, 1'b0);
    wr(REG_CTRL, 32'h84); chk(reject_req, 1'b1);
    cyc(1); chk(ri_n, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
